/* hdl/comparator_control_logic.sv */
// comparator control: source select, reference control, events, registers
`timescale 1ns/1ns
module comparator_control_logic (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire comparator_pkg::wb_req_t     wbReq,
  output logic [31:0]                      wbDatOut,
  output logic                             wbAck,
  input  wire logic                        comparisonResult,
  output comparator_pkg::analog_ctrl_t     analogCtrl,
  output logic                             comparatorOutputPin,
  output logic                             adcTrigger,
  output logic                             irq
);

  ////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [3:0] tapSelect;
  logic       referenceRange;
  logic       ladderEnable;
  logic       invertOut;
  logic [1:0] irqSense;
  logic [1:0] trgSense;
  logic [1:0] positiveSource;
  logic       trgEnable;
  logic       irqEnable;
  logic       rawIrq;
  logic       syncA;
  logic       syncB;
  logic       resultSync;
  logic       resultPrev;
  logic       irqEvent;
  logic       trgEvent;
  logic       access;
  logic       writeHit;
  logic       clearHit;
  logic       reserved;

  // a request is taken once; ack drops the cycle after it was given
  assign access = wbReq.cyc & wbReq.stb & ~wbAck;
  assign writeHit = access & wbReq.we & wbReq.sel[0];
  assign reserved = (positiveSource == comparator_pkg::SRC_RESERVED);

  ////////////////////////////////////////////////////////////////////////
  // wishbone ack: registered, one wait cycle per access
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= access;
    end
  end

  // writable registers; byte lane 0 for low bits, lane 1 for bits 15:8
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tapSelect      <= 4'h0;
      referenceRange <= 1'b0;
      ladderEnable   <= 1'b0;
      invertOut      <= 1'b0;
      irqSense       <= 2'h0;
      trgSense       <= 2'h0;
      positiveSource <= 2'h0;
      trgEnable      <= 1'b0;
      irqEnable      <= 1'b0;
    end else if (access && wbReq.we) begin
      case (wbReq.adr)
        comparator_pkg::OFF_IRQ_ENABLE: begin
          if (wbReq.sel[0]) begin
            irqEnable <= wbReq.dat[comparator_pkg::IRQ_BIT];
          end
        end
        comparator_pkg::OFF_REF_CTRL: begin
          if (wbReq.sel[0]) begin
            tapSelect <= wbReq.dat[comparator_pkg::TAP_MSB:
                                   comparator_pkg::TAP_LSB];
          end
          if (wbReq.sel[1]) begin
            referenceRange <= wbReq.dat[comparator_pkg::RANGE_BIT];
            ladderEnable   <= wbReq.dat[comparator_pkg::LADDER_EN_BIT];
          end
        end
        comparator_pkg::OFF_CONTROL: begin
          if (wbReq.sel[0]) begin
            invertOut <= wbReq.dat[comparator_pkg::INVERT_BIT];
            irqSense  <= wbReq.dat[comparator_pkg::IRQ_SENSE_MSB:
                                   comparator_pkg::IRQ_SENSE_LSB];
            trgSense  <= wbReq.dat[comparator_pkg::TRG_SENSE_MSB:
                                   comparator_pkg::TRG_SENSE_LSB];
          end
          if (wbReq.sel[1]) begin
            positiveSource <= wbReq.dat[comparator_pkg::SRC_MSB:
                                        comparator_pkg::SRC_LSB];
            trgEnable      <= wbReq.dat[comparator_pkg::TRG_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog controls: negative side is hard-wired to its pin, no selector
  always_comb begin
    analogCtrl.positiveSource = positiveSource;
    analogCtrl.useInternalRef =
      (positiveSource == comparator_pkg::SRC_INTERNAL);
    analogCtrl.ladderEnable   = ladderEnable;
    analogCtrl.referenceRange = referenceRange;
    analogCtrl.tapSelect      = tapSelect;
  end

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; syncA feeds syncB only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end else begin
      syncA <= comparisonResult;
      syncB <= syncA;
    end
  end

  // reserved source holds the last result so no spurious edge appears
  always_ff @(posedge clk) begin
    if (!resetn) begin
      resultSync <= 1'b0;
      resultPrev <= 1'b0;
    end else begin
      if (!reserved) begin
        resultSync <= syncB;
      end
      resultPrev <= resultSync;
    end
  end

  // edge detection, separately for interrupt and trigger
  function automatic logic senseHit(input logic [1:0] sense,
                                    input logic cur, input logic prev);
    case (sense)
      comparator_pkg::SENSE_LEVEL:   senseHit = cur;
      comparator_pkg::SENSE_FALLING: senseHit = prev & ~cur;
      comparator_pkg::SENSE_RISING:  senseHit = cur & ~prev;
      comparator_pkg::SENSE_BOTH:    senseHit = cur ^ prev;
      default:                       senseHit = 1'b0;
    endcase
  endfunction

  assign irqEvent = senseHit(irqSense, resultSync, resultPrev);
  assign trgEvent = senseHit(trgSense, resultSync, resultPrev);

  ////////////////////////////////////////////////////////////////////////
  // raw interrupt: set wins over a write-1 clear in the same cycle
  assign clearHit = writeHit && (wbReq.adr == comparator_pkg::OFF_MASKED_IRQ)
                    && wbReq.dat[comparator_pkg::IRQ_BIT];
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rawIrq <= 1'b0;
    end else if (irqEvent) begin
      rawIrq <= 1'b1;
    end else if (clearHit) begin
      rawIrq <= 1'b0;
    end
  end

  assign irq = rawIrq & irqEnable;

  // trigger pulse, one cycle per event when enabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      adcTrigger <= 1'b0;
    end else begin
      adcTrigger <= trgEnable & trgEvent;
    end
  end

  // output pin from a flop, optional inversion
  always_ff @(posedge clk) begin
    if (!resetn) begin
      comparatorOutputPin <= 1'b0;
    end else begin
      comparatorOutputPin <= resultSync ^ invertOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered alongside ack; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wbDatOut <= comparator_pkg::RESET_WORD;
    end else if (access && !wbReq.we) begin
      wbDatOut <= comparator_pkg::RESET_WORD;
      case (wbReq.adr)
        comparator_pkg::OFF_MASKED_IRQ:
          wbDatOut[comparator_pkg::IRQ_BIT] <= irq;
        comparator_pkg::OFF_RAW_IRQ:
          wbDatOut[comparator_pkg::IRQ_BIT] <= rawIrq;
        comparator_pkg::OFF_IRQ_ENABLE:
          wbDatOut[comparator_pkg::IRQ_BIT] <= irqEnable;
        comparator_pkg::OFF_REF_CTRL: begin
          wbDatOut[comparator_pkg::TAP_MSB:comparator_pkg::TAP_LSB]
            <= tapSelect;
          wbDatOut[comparator_pkg::RANGE_BIT]     <= referenceRange;
          wbDatOut[comparator_pkg::LADDER_EN_BIT] <= ladderEnable;
        end
        comparator_pkg::OFF_STATE:
          wbDatOut[comparator_pkg::OUT_VALUE_BIT] <= resultSync;
        comparator_pkg::OFF_CONTROL: begin
          wbDatOut[comparator_pkg::INVERT_BIT] <= invertOut;
          wbDatOut[comparator_pkg::IRQ_SENSE_MSB:
                   comparator_pkg::IRQ_SENSE_LSB] <= irqSense;
          wbDatOut[comparator_pkg::TRG_SENSE_MSB:
                   comparator_pkg::TRG_SENSE_LSB] <= trgSense;
          wbDatOut[comparator_pkg::SRC_MSB:comparator_pkg::SRC_LSB]
            <= positiveSource;
          wbDatOut[comparator_pkg::TRG_EN_BIT] <= trgEnable;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_rise;
    !resultPrev && resultSync;
  endsequence

  // the three sampling edges must all lie outside reset, else the flops
  // hold zero while the input history may be high
  property p_sync_delay;
    @(posedge clk) disable iff (!resetn)
      $past(resetn) && $past(resetn, 2) && $past(resetn, 3)
      && !reserved && $past(!reserved) && $past(!reserved, 2)
      |-> resultSync == $past(comparisonResult, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("result not synced through two stages");

  // clearing the enable over the bus must block the line the next cycle
  property p_irq_gate;
    @(posedge clk) disable iff (!resetn)
      writeHit && (wbReq.adr == comparator_pkg::OFF_IRQ_ENABLE)
      && !wbReq.dat[comparator_pkg::IRQ_BIT] |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated by enable");

  property p_irq_set;
    @(posedge clk) disable iff (!resetn)
      (irqSense == comparator_pkg::SENSE_RISING) and s_rise |=> rawIrq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("rising edge did not raise interrupt");

  property p_irq_clear;
    @(posedge clk) disable iff (!resetn)
      clearHit && !irqEvent |=> !rawIrq;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("write one did not clear interrupt");

  property p_trigger;
    @(posedge clk) disable iff (!resetn)
      trgEnable && trgEvent |=> adcTrigger;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger pulse missing");

  property p_no_trig_off;
    @(posedge clk) disable iff (!resetn) !trgEnable |=> !adcTrigger;
  endproperty
  a_no_trig_off: assert property (p_no_trig_off)
    else $error("trigger while disabled");

  property p_reserved_hold;
    @(posedge clk) disable iff (!resetn)
      reserved ##1 reserved |-> $stable(resultSync);
  endproperty
  a_reserved_hold: assert property (p_reserved_hold)
    else $error("result moved under reserved source");

  // a control write picks the reference only for source code 10
  property p_src_route;
    @(posedge clk) disable iff (!resetn)
      access && wbReq.we && wbReq.sel[1]
      && (wbReq.adr == comparator_pkg::OFF_CONTROL)
      |=> analogCtrl.useInternalRef
          == ($past(wbReq.dat[comparator_pkg::SRC_MSB])
              && !$past(wbReq.dat[comparator_pkg::SRC_LSB]));
  endproperty
  a_src_route: assert property (p_src_route)
    else $error("internal reference routing wrong");

  property p_pin_follows;
    @(posedge clk) disable iff (!resetn)
      $past(resetn) |-> comparatorOutputPin == $past(resultSync ^ invertOut);
  endproperty
  a_pin_follows: assert property (p_pin_follows)
    else $error("output pin does not follow result");

endmodule // comparator_control_logic

/* shared/comparator_pkg.sv */
// package: register map, field layout and carrier types for the comparator
package comparator_pkg;
  // register byte offsets (word aligned)
  localparam logic [7:0] OFF_MASKED_IRQ = 8'h00;
  localparam logic [7:0] OFF_RAW_IRQ    = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_REF_CTRL   = 8'h10;
  localparam logic [7:0] OFF_STATE      = 8'h20;
  localparam logic [7:0] OFF_CONTROL    = 8'h24;
  // field positions
  localparam int IRQ_BIT        = 0;
  localparam int OUT_VALUE_BIT  = 1;
  localparam int TAP_LSB        = 0;
  localparam int TAP_MSB        = 3;
  localparam int RANGE_BIT      = 8;
  localparam int LADDER_EN_BIT  = 9;
  localparam int INVERT_BIT     = 1;
  localparam int IRQ_SENSE_LSB  = 2;
  localparam int IRQ_SENSE_MSB  = 3;
  localparam int SRC_LSB        = 9;
  localparam int SRC_MSB        = 10;
  localparam int TRG_EN_BIT     = 11;
  localparam int TRG_SENSE_LSB  = 5;
  localparam int TRG_SENSE_MSB  = 6;
  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // positive-source codes
  localparam logic [1:0] SRC_PIN_A    = 2'h0;
  localparam logic [1:0] SRC_PIN_B    = 2'h1;
  localparam logic [1:0] SRC_INTERNAL = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;
  // edge sense codes
  localparam logic [1:0] SENSE_LEVEL   = 2'h0;
  localparam logic [1:0] SENSE_FALLING = 2'h1;
  localparam logic [1:0] SENSE_RISING  = 2'h2;
  localparam logic [1:0] SENSE_BOTH    = 2'h3;

  // analog-side controls driven to the ladder and the input mux
  typedef struct packed {
    logic [1:0] positiveSource;
    logic       useInternalRef;
    logic       ladderEnable;
    logic       referenceRange;
    logic [3:0] tapSelect;
  } analog_ctrl_t;

  // wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage

/* tb/comparator_analog_model.sv */
// behavioural far side: positive mux, reference ladder, comparator core
`timescale 1ns/1ns
module comparator_analog_model #(
  parameter int SUPPLY_MV = 3300
) (
  input  wire comparator_pkg::analog_ctrl_t analogCtrl,
  input  wire logic [15:0]                  positivePinMv,
  input  wire logic [15:0]                  negativePinMv,
  output logic                              comparisonResult
);
  int refMv;
  int plusMv;
  ////////////////////////////////////////////////////////////////////////////
  // ladder tap in millivolts; an unpowered ladder sits at ground
  always_comb begin
    if (!analogCtrl.ladderEnable) begin
      refMv = 0;
    end else if (analogCtrl.referenceRange) begin
      refMv = SUPPLY_MV * int'(analogCtrl.tapSelect) / 24;
    end else begin
      refMv = SUPPLY_MV * (int'(analogCtrl.tapSelect) + 8) / 32;
    end
  end
  // reserved code still lets the pin through: undefined, not quiet
  always_comb begin
    case (analogCtrl.positiveSource)
      2'h2:    plusMv = refMv;
      default: plusMv = int'(positivePinMv);
    endcase
  end
  // negative side always from its own pin
  assign comparisonResult = int'(negativePinMv) < plusMv;
endmodule // comparator_analog_model

/* tb/comparator_control_logic_tb_top.sv */
// testbench: register cycles, result path, interrupt and trigger events
`timescale 1ns/1ns
`define CHK(n, e, g) chk(n, e, g)
module comparator_control_logic_tb_top;
  logic                         clk = 1'b0;
  logic                         resetn;
  comparator_pkg::wb_req_t      wbReq;
  logic [31:0]                  wbDatOut;
  logic                         wbAck;
  logic                         comparisonResult;
  comparator_pkg::analog_ctrl_t analogCtrl;
  logic                         comparatorOutputPin;
  logic                         adcTrigger;
  logic                         irq;
  logic [15:0]                  posMv;
  logic [15:0]                  negMv;
  int                           bad_count = 0;
  int                           tests_run = 0;
  int                           trigCount = 0;
  int                           trigBase;
  logic [7:0]                   offs [7] = '{8'h00, 8'h04, 8'h08, 8'h10,
                                             8'h20, 8'h24, 8'h30};
  ////////////////////////////////////////////////////////////////////////////
  comparator_control_logic u_comparator_control_logic (
    .clk(clk), .resetn(resetn), .wbReq(wbReq), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .comparisonResult(comparisonResult),
    .analogCtrl(analogCtrl), .comparatorOutputPin(comparatorOutputPin),
    .adcTrigger(adcTrigger), .irq(irq));
  comparator_analog_model u_comparator_analog_model (
    .analogCtrl(analogCtrl), .positivePinMv(posMv), .negativePinMv(negMv),
    .comparisonResult(comparisonResult));
  always #4 clk = ~clk;
  // count trigger cycles; a level instead of a pulse shows up as extra
  always @(posedge clk) begin
    if (adcTrigger === 1'b1) begin
      trigCount <= trigCount + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // classic cycle, entered just after an edge; held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    @(posedge clk);
    while (wbAck !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) bad_count++;
    q = wbDatOut;
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(n, e, q);
  endtask
  // input change then a wait longer than the fixed four-cycle path
  task automatic setIn(input logic [15:0] p, n);
    posMv <= p;
    negMv <= n;
    repeat (6) @(posedge clk);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    wbReq = '0;
    posMv = 16'h07D0;
    negMv = 16'h09C4;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rdc("reset", offs[i], 32'h0000_0000);
    wr(8'h10, 32'h0000_030F);
    rdc("refctl", 8'h10, 32'h0000_030F);
    `CHK("tap", 32'h0000_000F, analogCtrl.tapSelect);
    // both pin codes route the positive pin
    for (int i = 0; i < 2; i++) begin
      wr(8'h24, 32'(i) << 9);
      `CHK("src", i, analogCtrl.positiveSource);
      setIn(16'h07D0, 16'h03E8);
      rdc("state", 8'h20, 32'h0000_0002);
      `CHK("pin", 1'h1, comparatorOutputPin);
      setIn(16'h07D0, 16'h09C4);
      rdc("state", 8'h20, 32'h0000_0000);
    end
    // internal ladder: range 0 tap 0 is 825 mV, range 1 tap 15 is 2062 mV
    wr(8'h24, 32'h0000_0400);
    wr(8'h10, 32'h0000_0200);
    `CHK("intref", 1'h1, analogCtrl.useInternalRef);
    setIn(16'h07D0, 16'h0320);
    rdc("state", 8'h20, 32'h0000_0002);
    setIn(16'h07D0, 16'h0352);
    rdc("state", 8'h20, 32'h0000_0000);
    wr(8'h10, 32'h0000_030F);
    setIn(16'h07D0, 16'h0802);
    rdc("state", 8'h20, 32'h0000_0002);
    negMv <= 16'h0834;
    repeat (2) @(posedge clk);
    `CHK("sync", 1'h1, comparatorOutputPin);
    repeat (4) @(posedge clk);
    `CHK("sync", 1'h0, comparatorOutputPin);
    // ground reference: range 1 tap 0 stays below a 1 mV negative pin
    wr(8'h10, 32'h0000_0300);
    setIn(16'h07D0, 16'h0001);
    rdc("gnd", 8'h20, 32'h0000_0000);
    // irq on rising, trigger on falling, pin source
    wr(8'h24, 32'h0000_0828);
    setIn(16'h07D0, 16'h09C4);
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    rdc("raw", 8'h04, 32'h0000_0000);
    trigBase = trigCount;
    setIn(16'h07D0, 16'h03E8);
    rdc("raw", 8'h04, 32'h0000_0001);
    `CHK("trg", 0, trigCount - trigBase);
    `CHK("irq", 1'h1, irq);
    rdc("masked", 8'h00, 32'h0000_0001);
    setIn(16'h07D0, 16'h09C4);
    `CHK("trg", 1, trigCount - trigBase);
    wr(8'h00, 32'h0000_0001);
    rdc("raw", 8'h04, 32'h0000_0000);
    `CHK("irq", 1'h0, irq);
    wr(8'h08, 32'h0000_0000);
    setIn(16'h07D0, 16'h03E8);
    rdc("masked", 8'h00, 32'h0000_0000);
    `CHK("irq", 1'h0, irq);
    // inverted pin
    wr(8'h24, 32'h0000_0002);
    `CHK("inv", 1'h0, comparatorOutputPin);
    // reserved source, both edges selected: nothing may fire
    wr(8'h24, 32'h0000_0E6C);
    wr(8'h00, 32'h0000_0001);
    trigBase = trigCount;
    setIn(16'h07D0, 16'h09C4);
    setIn(16'h07D0, 16'h03E8);
    `CHK("trg", 0, trigCount - trigBase);
    rdc("raw", 8'h04, 32'h0000_0000);
    end_of_test();
  end
endmodule // comparator_control_logic_tb_top
